// ### hdl/ocd_alu.sv
// datapath: result byte, new flags and destination for one opcode class
`include "ocd_map.svh"
module ocd_alu (
    ocd_alu_if.alu bus
);
    logic [7:0] src;
    logic [8:0] diff;
    logic [7:0] mask;
    logic andZero;
    logic setNz;

    assign src = bus.accMode ? bus.a : bus.m;
    assign diff = {1'b0, bus.a} - {1'b0, bus.m} -
                  {8'h00, ~bus.p[`OCD_P_C]};
    assign mask = 8'h01 << bus.bitSel;
    assign andZero = (bus.a & bus.m) == 8'h00;

    always_comb begin
        bus.res = 8'h00;
        bus.newP = bus.p;
        bus.wrA = 1'b0;
        bus.wrX = 1'b0;
        bus.wrY = 1'b0;
        bus.wrS = 1'b0;
        bus.wrM = 1'b0;
        setNz = 1'b0;
        case (bus.cls)
            ocd_pkg::CL_ROTR: begin
                bus.res = {bus.p[`OCD_P_C], src[7:1]};
                bus.newP[`OCD_P_C] = src[0];
                setNz = 1'b1;
            end
            ocd_pkg::CL_ROTL: begin
                bus.res = {src[6:0], bus.p[`OCD_P_C]};
                bus.newP[`OCD_P_C] = src[7];
                setNz = 1'b1;
            end
            ocd_pkg::CL_SHL: begin
                bus.res = {src[6:0], 1'b0};
                bus.newP[`OCD_P_C] = src[7];
                setNz = 1'b1;
            end
            ocd_pkg::CL_SHR: begin
                bus.res = {1'b0, src[7:1]};
                bus.newP[`OCD_P_C] = src[0];
                setNz = 1'b1;
            end
            ocd_pkg::CL_IRET: bus.newP = bus.m | `OCD_P_FIXED;
            ocd_pkg::CL_SUBB: begin
                bus.res = diff[7:0];
                bus.wrA = 1'b1;
                bus.newP[`OCD_P_C] = ~diff[8];
                bus.newP[`OCD_P_V] = (bus.a[7] ^ bus.m[7]) &
                                     (bus.a[7] ^ diff[7]);
                setNz = 1'b1;
            end
            ocd_pkg::CL_SETC: bus.newP[`OCD_P_C] = 1'b1;
            ocd_pkg::CL_SETD: bus.newP[`OCD_P_D] = 1'b1;
            ocd_pkg::CL_SETI: bus.newP[`OCD_P_I] = 1'b1;
            ocd_pkg::CL_BSET: begin
                {bus.res, bus.wrM} = {bus.m | mask, 1'b1};
            end
            ocd_pkg::CL_BCLR: begin
                {bus.res, bus.wrM} = {bus.m & ~mask, 1'b1};
            end
            ocd_pkg::CL_STORE_A: {bus.res, bus.wrM} = {bus.a, 1'b1};
            ocd_pkg::CL_STORE_X: {bus.res, bus.wrM} = {bus.x, 1'b1};
            ocd_pkg::CL_STORE_Y: begin
                {bus.res, bus.wrM} = {bus.y, 1'b1};
            end
            ocd_pkg::CL_STORE_0: bus.wrM = 1'b1;
            ocd_pkg::CL_A2X: {bus.res, bus.wrX, setNz} = {bus.a, 2'h3};
            ocd_pkg::CL_A2Y: {bus.res, bus.wrY, setNz} = {bus.a, 2'h3};
            ocd_pkg::CL_S2X: {bus.res, bus.wrX, setNz} = {bus.s, 2'h3};
            ocd_pkg::CL_X2A: {bus.res, bus.wrA, setNz} = {bus.x, 2'h3};
            ocd_pkg::CL_Y2A: {bus.res, bus.wrA, setNz} = {bus.y, 2'h3};
            ocd_pkg::CL_X2S: {bus.res, bus.wrS} = {bus.x, 1'b1};
            ocd_pkg::CL_TSTRST: begin
                bus.res = bus.m & ~bus.a;
                bus.wrM = 1'b1;
                bus.newP[`OCD_P_Z] = andZero;
            end
            ocd_pkg::CL_TSTSET: begin
                bus.res = bus.m | bus.a;
                bus.wrM = 1'b1;
                bus.newP[`OCD_P_Z] = andZero;
            end
            ocd_pkg::CL_PROBE: begin
                bus.newP[`OCD_P_N] = bus.m[7];
                bus.newP[`OCD_P_V] = bus.m[6];
                bus.newP[`OCD_P_Z] = andZero;
            end
            default: bus.res = 8'h00;
        endcase
        if (setNz) begin
            bus.newP[`OCD_P_N] = bus.res[7];
            bus.newP[`OCD_P_Z] = bus.res == 8'h00;
        end
        if (bus.accMode && setNz && !bus.wrA && !bus.wrX && !bus.wrY) begin
            bus.wrA = 1'b1;
        end else if (!bus.accMode && (bus.cls == ocd_pkg::CL_ROTR ||
                 bus.cls == ocd_pkg::CL_ROTL || bus.cls == ocd_pkg::CL_SHL ||
                 bus.cls == ocd_pkg::CL_SHR)) begin
            bus.wrM = 1'b1;
        end
    end
endmodule

// ### hdl/ocd_decode_tail.sv
// opcode decode tail: decode, flag effects, halt and idle control
`include "ocd_map.svh"
module ocd_decode_tail (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic phaseTwoClk,
    input wire logic readyLineI,
    output logic readyLineO,
    output logic readyLineOe,
    output logic memWrite,
    output logic [7:0] memData
);
    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic ack_ff;
    logic [31:0] rdData_ff;
    logic [7:0] opcode_ff, oper_ff, acc_ff, xReg_ff, yReg_ff, sPtr_ff;
    logic [7:0] flags_ff, memData_ff;
    logic memWrite_ff, phase_two_clock_ff, rdyMeta_ff, rdySync_ff;
    ocd_pkg::ocd_state_t state_ff, nxt_state;
    logic [7:0] nxt_acc, nxt_xReg, nxt_yReg, nxt_sPtr, nxt_flags;
    logic [31:0] rdMux;

    ocd_alu_if aluBus ();
    ocd_alu uAlu (
        .bus(aluBus)
    );

    // ----------------------------------------------------------------
    // opcode decode
    // ----------------------------------------------------------------
    function automatic ocd_pkg::ocd_class_t decodeOp(input logic [7:0] op);
        case (op)
            8'h6E, 8'h7E, 8'h6A, 8'h66, 8'h76: decodeOp = ocd_pkg::CL_ROTR;
            8'h2E, 8'h3E, 8'h2A, 8'h26, 8'h36: decodeOp = ocd_pkg::CL_ROTL;
            8'h0E, 8'h1E, 8'h0A, 8'h06, 8'h16: decodeOp = ocd_pkg::CL_SHL;
            8'h4E, 8'h5E, 8'h4A, 8'h46, 8'h56: decodeOp = ocd_pkg::CL_SHR;
            8'h40: decodeOp = ocd_pkg::CL_IRET;
            8'h60: decodeOp = ocd_pkg::CL_SRET;
            8'hED, 8'hFD, 8'hF9, 8'hE9, 8'hE5, 8'hE1, 8'hF5, 8'hF2,
            8'hF1: decodeOp = ocd_pkg::CL_SUBB;
            8'h38: decodeOp = ocd_pkg::CL_SETC;
            8'hF8: decodeOp = ocd_pkg::CL_SETD;
            8'h78: decodeOp = ocd_pkg::CL_SETI;
            8'h87, 8'h97, 8'hA7, 8'hB7, 8'hC7, 8'hD7, 8'hE7,
            8'hF7: decodeOp = ocd_pkg::CL_BSET;
            8'h07, 8'h17, 8'h27, 8'h37, 8'h47, 8'h57, 8'h67,
            8'h77: decodeOp = ocd_pkg::CL_BCLR;
            8'h8D, 8'h9D, 8'h99, 8'h85, 8'h81, 8'h95, 8'h92,
            8'h91: decodeOp = ocd_pkg::CL_STORE_A;
            8'h8E, 8'h86, 8'h96: decodeOp = ocd_pkg::CL_STORE_X;
            8'h8C, 8'h84, 8'h94: decodeOp = ocd_pkg::CL_STORE_Y;
            8'h9C, 8'h9E, 8'h64,
            8'h74: decodeOp = ocd_pkg::CL_STORE_0;
            8'hAA: decodeOp = ocd_pkg::CL_A2X;
            8'hA8: decodeOp = ocd_pkg::CL_A2Y;
            8'hBA: decodeOp = ocd_pkg::CL_S2X;
            8'h8A: decodeOp = ocd_pkg::CL_X2A;
            8'h98: decodeOp = ocd_pkg::CL_Y2A;
            8'h9A: decodeOp = ocd_pkg::CL_X2S;
            8'h1C, 8'h14: decodeOp = ocd_pkg::CL_TSTRST;
            8'h0C, 8'h04: decodeOp = ocd_pkg::CL_TSTSET;
            8'hDB: decodeOp = ocd_pkg::CL_HALT;
            8'hCB: decodeOp = ocd_pkg::CL_IDLE;
            8'h24, 8'h2C, 8'h34, 8'h3C,
            8'h89: decodeOp = ocd_pkg::CL_PROBE;
            default: decodeOp = ocd_pkg::CL_NONE;
        endcase
    endfunction

    // ----------------------------------------------------------------
    // bus decode
    // ----------------------------------------------------------------
    wire busReq = wb_cyc_i & wb_stb_i;
    wire wrTake = busReq & wb_we_i & ack_ff & wb_sel_i[0];
    wire [7:0] wrByte = wb_dat_i[7:0];
    wire hitOpcode = wb_adr_i == `OCD_ADR_OPCODE;
    wire hitOper = wb_adr_i == `OCD_ADR_OPER;
    wire hitAcc = wb_adr_i == `OCD_ADR_ACC;
    wire hitXReg = wb_adr_i == `OCD_ADR_XREG;
    wire hitYReg = wb_adr_i == `OCD_ADR_YREG;
    wire hitSPtr = wb_adr_i == `OCD_ADR_SPTR;
    wire hitFlags = wb_adr_i == `OCD_ADR_FLAGS;
    wire hitMemOut = wb_adr_i == `OCD_ADR_MEMOUT;
    wire hitStatus = wb_adr_i == `OCD_ADR_STATUS;
    wire hitEvent = wb_adr_i == `OCD_ADR_EVENT;
    wire isRun = state_ff == ocd_pkg::ST_RUN;
    wire opWr = wrTake & hitOpcode & isRun;
    wire restartTake = wrTake & hitEvent & wrByte[`OCD_EV_RESTART];
    wire irqTake = wrTake & hitEvent & wrByte[`OCD_EV_IRQ];
    wire regWr = wrTake & isRun;

    // ----------------------------------------------------------------
    // datapath hookup
    // ----------------------------------------------------------------
    assign aluBus.cls = decodeOp(wrByte);
    assign aluBus.accMode = wrByte[3:0] == 4'hA && !wrByte[7];
    assign aluBus.bitSel = wrByte[6:4];
    assign aluBus.a = acc_ff;
    assign aluBus.x = xReg_ff;
    assign aluBus.y = yReg_ff;
    assign aluBus.s = sPtr_ff;
    assign aluBus.p = flags_ff;
    assign aluBus.m = oper_ff;

    assign nxt_acc = (opWr & aluBus.wrA) ? aluBus.res :
                     (regWr & hitAcc) ? wrByte : acc_ff;
    assign nxt_xReg = (opWr & aluBus.wrX) ? aluBus.res :
                      (regWr & hitXReg) ? wrByte : xReg_ff;
    assign nxt_yReg = (opWr & aluBus.wrY) ? aluBus.res :
                      (regWr & hitYReg) ? wrByte : yReg_ff;
    assign nxt_sPtr = (opWr & aluBus.wrS) ? aluBus.res :
                      (regWr & hitSPtr) ? wrByte : sPtr_ff;
    // interrupt entry masks and forces binary mode
    assign nxt_flags = irqTake ?
        ((flags_ff & ~(8'h01 << `OCD_P_D)) | (8'h01 << `OCD_P_I)) :
        opWr ? aluBus.newP :
        (regWr & hitFlags) ? (wrByte | `OCD_P_FIXED) : flags_ff;

    // ----------------------------------------------------------------
    // run, halt and idle control
    // ----------------------------------------------------------------
    always_comb begin
        case (state_ff)
            ocd_pkg::ST_RUN: begin
                if (opWr && aluBus.cls == ocd_pkg::CL_HALT) begin
                    nxt_state = ocd_pkg::ST_HALT;
                end else if (opWr && aluBus.cls == ocd_pkg::CL_IDLE) begin
                    nxt_state = ocd_pkg::ST_IDLE;
                end else begin
                    nxt_state = ocd_pkg::ST_RUN;
                end
            end
            ocd_pkg::ST_IDLE: begin
                nxt_state = irqTake ? ocd_pkg::ST_RUN : ocd_pkg::ST_IDLE;
            end
            ocd_pkg::ST_HALT: begin
                nxt_state = restartTake ? ocd_pkg::ST_RUN : ocd_pkg::ST_HALT;
            end
            default: nxt_state = ocd_pkg::ST_RUN;
        endcase
    end

    // phase two divider, frozen high while halted
    wire nxt_phase_two_clock = (nxt_state == ocd_pkg::ST_HALT) | ~phase_two_clock_ff;

    // ----------------------------------------------------------------
    // read mux
    // ----------------------------------------------------------------
    wire [7:0] statusByte = {5'h00, rdySync_ff,
                             state_ff == ocd_pkg::ST_IDLE,
                             state_ff == ocd_pkg::ST_HALT};
    assign rdMux = hitOpcode ? {24'h000000, opcode_ff} :
                   hitOper ? {24'h000000, oper_ff} :
                   hitAcc ? {24'h000000, acc_ff} :
                   hitXReg ? {24'h000000, xReg_ff} :
                   hitYReg ? {24'h000000, yReg_ff} :
                   hitSPtr ? {24'h000000, sPtr_ff} :
                   hitFlags ? {24'h000000, flags_ff} :
                   hitMemOut ? {24'h000000, memData_ff} :
                   hitStatus ? {24'h000000, statusByte} : 32'h00000000;

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ack_ff <= 1'b0;
            rdData_ff <= 32'h00000000;
        end else begin
            ack_ff <= busReq & ~ack_ff;
            rdData_ff <= rdMux;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            acc_ff <= `OCD_RST_BYTE;
            xReg_ff <= `OCD_RST_BYTE;
            yReg_ff <= `OCD_RST_BYTE;
            sPtr_ff <= `OCD_RST_SPTR;
            flags_ff <= `OCD_RST_FLAGS;
        end else begin
            acc_ff <= nxt_acc;
            xReg_ff <= nxt_xReg;
            yReg_ff <= nxt_yReg;
            sPtr_ff <= nxt_sPtr;
            flags_ff <= nxt_flags;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            opcode_ff <= `OCD_RST_BYTE;
            oper_ff <= `OCD_RST_BYTE;
        end else begin
            opcode_ff <= opWr ? wrByte : opcode_ff;
            oper_ff <= (regWr & hitOper) ? wrByte : oper_ff;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            memData_ff <= `OCD_RST_BYTE;
            memWrite_ff <= 1'b0;
        end else begin
            memWrite_ff <= opWr & aluBus.wrM;
            memData_ff <= (opWr & aluBus.wrM) ? aluBus.res : memData_ff;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_ff <= ocd_pkg::ST_RUN;
            phase_two_clock_ff <= 1'b0;
            rdyMeta_ff <= 1'b1;
            rdySync_ff <= 1'b1;
        end else begin
            state_ff <= nxt_state;
            phase_two_clock_ff <= nxt_phase_two_clock;
            rdyMeta_ff <= readyLineI;
            rdySync_ff <= rdyMeta_ff;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign wb_ack_o = ack_ff;
    assign wb_dat_o = rdData_ff;
    assign phaseTwoClk = phase_two_clock_ff;
    assign readyLineO = 1'b0;
    assign readyLineOe = state_ff == ocd_pkg::ST_IDLE;
    assign memWrite = memWrite_ff;
    assign memData = memData_ff;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    rotr_acc_a: assert property (opWr && wrByte == 8'h6A |=>
        acc_ff == {$past(flags_ff[0]), $past(acc_ff[7:1])} &&
        flags_ff[0] == $past(acc_ff[0]))
        else $error("rotate right result wrong");
    iret_flags_a: assert property (opWr && wrByte == 8'h40 |=>
        flags_ff == ($past(oper_ff) | 8'h30))
        else $error("interrupt return flags wrong");
    sret_keep_a: assert property (opWr && wrByte == 8'h60 |=>
        flags_ff == $past(flags_ff))
        else $error("subroutine return changed flags");
    subb_diff_a: assert property (opWr && wrByte == 8'hE9 |=>
        acc_ff == 8'($past(acc_ff) - $past(oper_ff) -
                     {7'h00, ~$past(flags_ff[0])}))
        else $error("subtract with borrow wrong");
    set_carry_a: assert property (opWr && wrByte == 8'h38 |=>
        flags_ff == ($past(flags_ff) | 8'h01))
        else $error("carry set wrong");
    bit_set_a: assert property (opWr && wrByte == 8'hA7 |=>
        memWrite && memData == ($past(oper_ff) | 8'h04) ##1 !memWrite)
        else $error("zero page bit set wrong");
    halt_clock_a: assert property (state_ff == ocd_pkg::ST_HALT &&
        !restartTake |-> phaseTwoClk [*2])
        else $error("phase two clock not held high");
    copy_nz_a: assert property (opWr && wrByte == 8'hAA |=>
        xReg_ff == $past(acc_ff) && flags_ff[7] == xReg_ff[7] &&
        flags_ff[1] == (xReg_ff == 8'h00))
        else $error("register copy flags wrong");
    idle_ready_a: assert property (opWr && wrByte == 8'hCB |=>
        readyLineOe && !readyLineO)
        else $error("ready line not pulled low");
    irq_binary_a: assert property (irqTake |=>
        !flags_ff[3] && flags_ff[2] && state_ff != ocd_pkg::ST_IDLE)
        else $error("interrupt entry flags wrong");
    shl_carry_a: assert property (opWr && wrByte == 8'h0A |=>
        acc_ff == {$past(acc_ff[6:0]), 1'b0} &&
        flags_ff[0] == $past(acc_ff[7]))
        else $error("shift left result wrong");
    shr_carry_a: assert property (opWr && wrByte == 8'h4A |=>
        acc_ff == {1'b0, $past(acc_ff[7:1])} &&
        flags_ff[0] == $past(acc_ff[0]))
        else $error("shift right result wrong");
    rotl_carry_a: assert property (opWr && wrByte == 8'h2A |=>
        acc_ff == {$past(acc_ff[6:0]), $past(flags_ff[0])} &&
        flags_ff[0] == $past(acc_ff[7]))
        else $error("rotate left result wrong");
    bit_clear_a: assert property (opWr && wrByte == 8'h37 |=>
        memWrite && memData == ($past(oper_ff) & 8'hF7))
        else $error("zero page bit clear wrong");
    store_acc_a: assert property (opWr && wrByte == 8'h85 |=>
        memWrite && memData == $past(acc_ff) &&
        flags_ff == $past(flags_ff))
        else $error("accumulator store wrong");
    store_x_a: assert property (opWr && wrByte == 8'h86 |=>
        memWrite && memData == $past(xReg_ff) &&
        flags_ff == $past(flags_ff))
        else $error("index x store wrong");
    store_zero_a: assert property (opWr && wrByte == 8'h64 |=>
        memWrite && memData == 8'h00 && flags_ff == $past(flags_ff))
        else $error("zero store wrong");
    tst_reset_a: assert property (opWr && wrByte == 8'h1C |=>
        memData == ($past(oper_ff) & ~$past(acc_ff)) &&
        (flags_ff & 8'hFD) == ($past(flags_ff) & 8'hFD))
        else $error("test and reset wrong");
    tst_set_a: assert property (opWr && wrByte == 8'h04 |=>
        memData == ($past(oper_ff) | $past(acc_ff)) &&
        (flags_ff & 8'hFD) == ($past(flags_ff) & 8'hFD))
        else $error("test and set wrong");
    probe_nv_a: assert property (opWr && wrByte == 8'h24 |=>
        flags_ff[7:6] == $past(oper_ff[7:6]))
        else $error("memory probe flags wrong");

    halt_seen_c: cover property (opWr && aluBus.cls == ocd_pkg::CL_HALT);
    idle_wake_c: cover property (state_ff == ocd_pkg::ST_IDLE ##1 irqTake);
    borrow_c: cover property (opWr && aluBus.cls == ocd_pkg::CL_SUBB &&
                              !aluBus.newP[0]);
    restart_c: cover property (state_ff == ocd_pkg::ST_HALT && restartTake);
    probe_c: cover property (opWr && aluBus.cls == ocd_pkg::CL_PROBE);
endmodule

// ### shared/ocd_alu_if.sv
// operand and result bundle between the decode core and its datapath
interface ocd_alu_if;
    ocd_pkg::ocd_class_t cls;
    logic accMode;
    logic [2:0] bitSel;
    logic [7:0] a, x, y, s, p, m;
    logic [7:0] res, newP;
    logic wrA, wrX, wrY, wrS, wrM;

    modport core (output cls, accMode, bitSel, a, x, y, s, p, m,
                  input res, newP, wrA, wrX, wrY, wrS, wrM);
    modport alu (input cls, accMode, bitSel, a, x, y, s, p, m,
                 output res, newP, wrA, wrX, wrY, wrS, wrM);
endinterface

// ### shared/ocd_map.svh
// register offsets, flag positions, reset values of the opcode decode tail
`ifndef OCD_MAP_SVH
`define OCD_MAP_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define OCD_ADR_OPCODE 8'h00
`define OCD_ADR_OPER 8'h04
`define OCD_ADR_ACC 8'h08
`define OCD_ADR_XREG 8'h0C
`define OCD_ADR_YREG 8'h10
`define OCD_ADR_SPTR 8'h14
`define OCD_ADR_FLAGS 8'h18
`define OCD_ADR_MEMOUT 8'h1C
`define OCD_ADR_STATUS 8'h20
`define OCD_ADR_EVENT 8'h24

// ----------------------------------------------------------------
// flag byte fields
// ----------------------------------------------------------------
`define OCD_P_N 7
`define OCD_P_V 6
`define OCD_P_D 3
`define OCD_P_I 2
`define OCD_P_Z 1
`define OCD_P_C 0
`define OCD_P_FIXED 8'h30

// ----------------------------------------------------------------
// status and event fields
// ----------------------------------------------------------------
`define OCD_ST_HALT 0
`define OCD_ST_IDLE 1
`define OCD_ST_RDYPIN 2
`define OCD_EV_RESTART 0
`define OCD_EV_IRQ 1

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define OCD_RST_FLAGS 8'h34
`define OCD_RST_SPTR 8'hFF
`define OCD_RST_BYTE 8'h00

`endif

// ### shared/ocd_pkg.sv
// types shared by the opcode decode tail modules
package ocd_pkg;

    typedef enum logic [4:0] {
        CL_NONE = 5'h00, CL_ROTR = 5'h01, CL_ROTL = 5'h02,
        CL_SHL = 5'h03, CL_SHR = 5'h04, CL_IRET = 5'h05,
        CL_SRET = 5'h06, CL_SUBB = 5'h07, CL_SETC = 5'h08,
        CL_SETD = 5'h09, CL_SETI = 5'h0A, CL_BSET = 5'h0B,
        CL_BCLR = 5'h0C, CL_STORE_A = 5'h0D, CL_STORE_X = 5'h0E,
        CL_STORE_Y = 5'h0F, CL_STORE_0 = 5'h10, CL_A2X = 5'h11,
        CL_A2Y = 5'h12, CL_S2X = 5'h13, CL_X2A = 5'h14,
        CL_X2S = 5'h15, CL_Y2A = 5'h16, CL_TSTRST = 5'h17,
        CL_TSTSET = 5'h18, CL_HALT = 5'h19, CL_IDLE = 5'h1A,
        CL_PROBE = 5'h1B
    } ocd_class_t;

    typedef enum logic [1:0] {
        ST_RUN = 2'h0,
        ST_IDLE = 2'h1,
        ST_HALT = 2'h2
    } ocd_state_t;

endpackage

// ### verification/cpu_opcode_decode_tail_tb.sv
// self-checking bench for the opcode decode tail
module cpu_opcode_decode_tail_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 0, rst = 1, cyc = 0, stb = 0, we = 0;
    logic [7:0] adr = 8'h00, mb, md, a, m, f, r, e;
    logic [31:0] din = 32'h0, dout;
    logic [3:0] sel = 4'h0, sl = 4'hF;
    logic ack, p2, rdyO, rdyOe, rdy, mw, c;
    logic [8:0] d9;
    logic [15:0] q[$];
    logic [7:0] ops[4] = '{8'h0A, 8'h4A, 8'h2A, 8'h6A};
    logic [7:0] sets[3] = '{8'h38, 8'hF8, 8'h78};
    logic [7:0] sts[4] = '{8'h85, 8'h86, 8'h84, 8'h64};
    integer n_errors = 0, compares = 0, seed = 11595, i;
    ocd_decode_tail dut_u (.clk_sys(clk_sys), .rst(rst), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(din), .wb_dat_o(dout), .wb_ack_o(ack),
        .phaseTwoClk(p2), .readyLineI(rdy), .readyLineO(rdyO),
        .readyLineOe(rdyOe), .memWrite(mw), .memData(md));
    ocd_mem_model mem_u (.clk_sys(clk_sys), .memWrite(mw),
        .memData(md), .readyLineO(rdyO), .readyLineOe(rdyOe),
        .readyLine(rdy), .lastByte(mb));
    initial forever #5 clk_sys = ~clk_sys;
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [7:0] ex, g);
        compares++;
        if (g !== ex) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", nm, ex, g);
        end
    endtask
    task tally_and_finish;
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic bus(input logic w, input logic [7:0] ad, d);
        integer k;
        @(posedge clk_sys);
        cyc <= 1;
        stb <= 1;
        we <= w;
        sel <= sl;
        adr <= ad;
        din <= {24'h0, d};
        k = 0;
        do begin
            @(posedge clk_sys);
            k++;
        end while (ack !== 1'b1 && k < 20);
        if (k >= 20) begin
            n_errors++;
            tally_and_finish;
        end
        cyc <= 0;
        stb <= 0;
    endtask
    task automatic rd(input logic [7:0] ad, ex);
        q.push_back({ad, ex});
        bus(0, ad, 8'h00);
    endtask
    function automatic logic [7:0] nz(input logic [7:0] p, v);
        nz = {v[7], p[6:2], v == 8'h00, p[0]};
    endfunction
    // watcher: compares each read answer with the oldest note
    always @(posedge clk_sys) begin : watch
        logic [15:0] t;
        if (ack === 1'b1 && we === 1'b0 && q.size() > 0) begin
            t = q.pop_front();
            chk($sformatf("reg %h", t[15:8]), t[7:0], dout[7:0]);
        end
    end
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (2) @(posedge clk_sys);
        rst <= 0;
        rd(8'h18, 8'h34);
        rd(8'h14, 8'hFF);
        rd(8'h40, 8'h00);
        for (i = 0; i < 4; i++) begin
            a = $random(seed);
            f = $random(seed) | 8'h30;
            c = f[0];
            bus(1, 8'h08, a);
            bus(1, 8'h18, f);
            bus(1, 8'h00, ops[i]);
            case (i)
                0: {c, r} = {a, 1'b0};
                1: {r, c} = {1'b0, a};
                2: {c, r} = {a, c};
                default: {r, c} = {c, a};
            endcase
            e = nz(f, r);
            e[0] = c;
            rd(8'h08, r);
            rd(8'h18, e);
        end
        a = $random(seed);
        m = $random(seed);
        bus(1, 8'h08, a);
        bus(1, 8'h04, m);
        bus(1, 8'h00, 8'hE9);
        d9 = {1'b0, a} - m - {8'h0, ~c};
        e = nz(f, d9[7:0]);
        e[0] = ~d9[8];
        e[6] = (a[7] ^ m[7]) & (a[7] ^ d9[7]);
        rd(8'h08, d9[7:0]);
        rd(8'h18, e);
        for (i = 0; i < 3; i++) begin
            bus(1, 8'h18, 8'h00);
            bus(1, 8'h00, sets[i]);
            e = i == 0 ? 8'h31 : i == 1 ? 8'h38 : 8'h34;
            rd(8'h18, e);
        end
        for (i = 0; i < 8; i++) begin
            bus(1, 8'h04, 8'h00);
            bus(1, 8'h00, {1'b1, i[2:0], 4'h7});
            rd(8'h1C, 8'h01 << i);
            bus(1, 8'h04, 8'hFF);
            bus(1, 8'h00, {1'b0, i[2:0], 4'h7});
            rd(8'h1C, ~(8'h01 << i));
        end
        bus(1, 8'h08, a);
        bus(1, 8'h0C, a + 8'h01);
        bus(1, 8'h10, a + 8'h02);
        bus(1, 8'h18, 8'h30);
        for (i = 0; i < 4; i++) begin
            bus(1, 8'h00, sts[i]);
            rd(8'h1C, i == 3 ? 8'h00 : a + i[7:0]);
        end
        chk("stored byte", 8'h00, mb);
        rd(8'h18, 8'h30);
        bus(1, 8'h08, 8'h80);
        bus(1, 8'h00, 8'hAA);
        rd(8'h0C, 8'h80);
        rd(8'h18, 8'hB0);
        bus(1, 8'h0C, 8'h00);
        bus(1, 8'h00, 8'h9A);
        rd(8'h14, 8'h00);
        bus(1, 8'h00, 8'h8A);
        rd(8'h18, 8'h32);
        bus(1, 8'h10, 8'hC1);
        bus(1, 8'h00, 8'h98);
        rd(8'h08, 8'hC1);
        bus(1, 8'h10, 8'h00);
        bus(1, 8'h00, 8'hA8);
        rd(8'h10, 8'hC1);
        rd(8'h18, 8'hB0);
        bus(1, 8'h00, 8'hBA);
        rd(8'h18, 8'h32);
        bus(1, 8'h08, 8'h0F);
        bus(1, 8'h04, 8'h3C);
        bus(1, 8'h00, 8'h04);
        rd(8'h1C, 8'h3F);
        rd(8'h18, 8'h30);
        bus(1, 8'h04, 8'hF0);
        bus(1, 8'h00, 8'h1C);
        rd(8'h1C, 8'hF0);
        rd(8'h18, 8'h32);
        bus(1, 8'h00, 8'h24);
        rd(8'h18, 8'hF2);
        bus(1, 8'h00, 8'h46);
        rd(8'h1C, 8'h78);
        rd(8'h18, 8'h70);
        bus(1, 8'h04, 8'hC3);
        bus(1, 8'h00, 8'h40);
        rd(8'h18, 8'hF3);
        bus(1, 8'h00, 8'h60);
        rd(8'h18, 8'hF3);
        bus(1, 8'h18, 8'h38);
        bus(1, 8'h00, 8'hCB);
        bus(1, 8'h08, 8'h55);
        rd(8'h20, 8'h02);
        chk("ready wire", 8'h00, {7'h0, rdy});
        bus(1, 8'h24, 8'h02);
        sl = 4'hE;
        bus(1, 8'h08, 8'hAA);
        sl = 4'hF;
        rd(8'h08, 8'h0F);
        rd(8'h18, 8'h34);
        bus(1, 8'h00, 8'hDB);
        repeat (3) begin
            @(posedge clk_sys);
            chk("phase two", 8'h01, {7'h0, p2});
        end
        rd(8'h20, 8'h05);
        bus(1, 8'h24, 8'h01);
        rd(8'h20, 8'h04);
        @(posedge clk_sys);
        tally_and_finish;
    end
endmodule

// ### verification/ocd_mem_model.sv
// far-side model: memory write capture and ready wire
module ocd_mem_model (
    input wire logic clk_sys,
    input wire logic memWrite,
    input wire logic [7:0] memData,
    input wire logic readyLineO,
    input wire logic readyLineOe,
    output logic readyLine,
    output logic [7:0] lastByte
);
    timeunit 1ns;
    timeprecision 1ps;
    // pull-up keeps the wire high unless the device drives it
    assign readyLine = readyLineOe ? readyLineO : 1'b1;
    initial lastByte = 8'h00;
    always @(posedge clk_sys) begin
        if (memWrite === 1'b1)
            lastByte <= memData;
    end
endmodule
